/* logic/charger_pkg.sv */
/*
 Shared constants and types for the charger supervisor and its serial
 register slave. Assumes a single 25 MHz core clock for both modules.
*/
package charger_pkg;

    // Core clock and the times derived from it
    localparam longint CLK_HZ         = 25_000_000;
    localparam longint NS_PER_S       = 1_000_000_000;
    localparam longint US_PER_S       = 1_000_000;
    localparam longint PULSE_TIME_NS  = 256_000;
    localparam longint PULSE_CYCLES   = PULSE_TIME_NS * CLK_HZ / NS_PER_S;
    localparam longint WD_TIME_S      = 50;
    localparam longint WD_CYCLES      = WD_TIME_S * CLK_HZ;
    localparam longint TICK_TIME_S    = 1;
    localparam longint TICK_CYCLES    = TICK_TIME_S * CLK_HZ;
    localparam longint DERATE_STEP_US = 1000;
    localparam longint DERATE_CYCLES  = DERATE_STEP_US * CLK_HZ / US_PER_S;
    localparam int     SEC_PER_MIN    = 60;

    // Safety timer advance per tick
    localparam logic [15:0] RATE_NORMAL = 16'h0001;
    localparam logic [15:0] RATE_FAST   = 16'h0002;

    // Register offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_TIMER  = 8'h05;

    // Status and timer register fields
    localparam int WD_FLAG_BIT = 7;
    localparam int WATCHDOG_ENABLE_BIT_BIT   = 6;
    localparam int STATE_LO    = 4;
    localparam int FAULT_LO    = 0;
    localparam int TSEL_LO     = 0;

    // Charge state codes
    localparam logic [1:0] CS_READY = 2'h0;
    localparam logic [1:0] CS_BUSY  = 2'h1;
    localparam logic [1:0] CS_DONE  = 2'h2;
    localparam logic [1:0] CS_FAULT = 2'h3;

    // Fault codes
    localparam logic [3:0] FC_NORMAL   = 4'h0;
    localparam logic [3:0] FC_IN_OVP   = 4'h1;
    localparam logic [3:0] FC_IN_UVLO  = 4'h2;
    localparam logic [3:0] FC_SLEEP    = 4'h3;
    localparam logic [3:0] FC_BAT_TEMP = 4'h4;
    localparam logic [3:0] FC_BAT_OVP  = 4'h5;
    localparam logic [3:0] FC_TSD      = 4'h6;
    localparam logic [3:0] FC_TIMER    = 4'h7;
    localparam logic [3:0] FC_NO_BAT   = 4'h8;
    localparam logic [3:0] FC_SET_SHORT = 4'h9;
    localparam logic [3:0] FC_LDO_LOW  = 4'ha;
    localparam int         NUM_FAULTS  = 10;

    // Serial byte kinds
    localparam logic [1:0] K_ADDR = 2'h0;
    localparam logic [1:0] K_PTR  = 2'h1;
    localparam logic [1:0] K_DATA = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_RX    = 5'b00010,
        S_ACK   = 5'b00100,
        S_TX    = 5'b01000,
        S_TXACK = 5'b10000
    } link_state_type;

    // Condition levels from the power stage, on the core clock
    typedef struct packed {
        logic charge_active;
        logic charge_done;
        logic precharge_linear;
        logic therm_reg;
        logic bat_temp_reduced;
        logic in_limit;
        logic in_ovp;
        logic in_uvlo;
        logic sleep;
        logic bat_temp_fault;
        logic bat_ovp;
        logic die_over_shutdown;
        logic die_below_restart;
        logic no_battery;
        logic set_pin_short;
        logic in_good_fault;
        logic ldo_low;
    } sense_type;

    typedef struct packed {
        logic       wr;
        logic       rd_done;
        logic [7:0] addr;
        logic [7:0] wdata;
    } regbus_type;

endpackage

/* logic/serial_reg_slave.sv */
/*
 Two-wire serial register slave: address byte, pointer byte, then data
 bytes written to or read from the pointer. Assumes SCL is much slower
 than the core clock; both pins are sampled through three flip-flops.
*/
`timescale 1ns/1ps
module serial_reg_slave #(
    // Arbitrary bus address
    parameter logic [6:0] DEV_ADDR = 7'h35
) (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    output charger_pkg::regbus_type      bus,
    input  wire logic [7:0]              rd_data
);
    import charger_pkg::*;

    typedef struct packed {
        link_state_type st;
        logic [2:0]     scl_s;
        logic [2:0]     sda_s;
        logic           scl_f;
        logic           sda_f;
        logic [1:0]     kind;
        logic [3:0]     cnt;
        logic [7:0]     sh;
        logic           rw;
        logic           cont;
        logic           oe;
        logic           dout;
        regbus_type     bus;
    } link_type;

    localparam link_type LINK_RESET = '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7,
                                        scl_f: 1'b1, sda_f: 1'b1, default: '0};

    link_type r;
    link_type n;

    always_comb begin
        logic scl_nf;
        logic sda_nf;
        logic rise;
        logic fall;
        scl_nf = r.scl_f;
        sda_nf = r.sda_f;
        n = r;
        n.bus.wr = 1'b0;
        n.bus.rd_done = 1'b0;
        n.scl_s = {r.scl_s[1:0], scl_in};
        n.sda_s = {r.sda_s[1:0], sda_in};
        // Accept a level only once the second and third stages agree
        if (r.scl_s[1] == r.scl_s[2]) begin
            scl_nf = r.scl_s[2];
        end
        if (r.sda_s[1] == r.sda_s[2]) begin
            sda_nf = r.sda_s[2];
        end
        n.scl_f = scl_nf;
        n.sda_f = sda_nf;
        rise = scl_nf & ~r.scl_f;
        fall = ~scl_nf & r.scl_f;
        if (r.scl_f && scl_nf && r.sda_f && !sda_nf) begin
            n.st = S_RX;
            n.kind = K_ADDR;
            n.cnt = '0;
            n.oe = 1'b0;
        end else if (r.scl_f && scl_nf && !r.sda_f && sda_nf) begin
            n.st = S_IDLE;
            n.oe = 1'b0;
        end else begin
            unique case (r.st)
                S_IDLE: begin
                    n.oe = 1'b0;
                end
                S_RX: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda_nf};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == BITS_PER_BYTE) begin
                        n.st = S_ACK;
                        n.oe = 1'b1;
                        if (r.kind == K_ADDR) begin
                            n.rw = r.sh[0];
                            if (r.sh[7:1] != DEV_ADDR) begin
                                n.st = S_IDLE;
                                n.oe = 1'b0;
                            end
                        end else if (r.kind == K_PTR) begin
                            n.bus.addr = r.sh;
                        end else begin
                            n.bus.wr = 1'b1;
                            n.bus.wdata = r.sh;
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        n.cnt = '0;
                        if (r.kind == K_ADDR && r.rw) begin
                            n.st = S_TX;
                            n.sh = rd_data;
                            n.oe = ~rd_data[7];
                            n.cnt = 4'h1;
                        end else begin
                            n.st = S_RX;
                            n.oe = 1'b0;
                            n.kind = (r.kind == K_ADDR) ? K_PTR : K_DATA;
                        end
                    end
                end
                S_TX: begin
                    if (fall) begin
                        if (r.cnt == BITS_PER_BYTE) begin
                            n.st = S_TXACK;
                            n.oe = 1'b0;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe = ~r.sh[6];
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                S_TXACK: begin
                    if (rise) begin
                        n.bus.rd_done = 1'b1;
                        n.cont = ~sda_nf;
                    end else if (fall) begin
                        if (r.cont) begin
                            n.st = S_TX;
                            n.sh = rd_data;
                            n.oe = ~rd_data[7];
                            n.cnt = 4'h1;
                        end else begin
                            n.st = S_IDLE;
                        end
                    end
                end
                default: begin
                    n.st = S_IDLE;
                    n.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            r <= LINK_RESET;
        end else begin
            r <= n;
        end
    end

    assign sda_out = r.dout;
    assign sda_oe  = r.oe;
    assign bus     = r.bus;

endmodule // serial_reg_slave

/* logic/charger_timer_fault_supervisor.sv */
/*
 Charger supervisor: safety timer, host watchdog, thermal control,
 fault policy and the status/control register with its fault queue.
 Assumes the power-stage condition levels arrive on the core clock and
 that the serial pins come straight from the package.
*/
// Notes on behaviour
// - Safety timer runs throughout each charging process
// - Safety expiry before termination suspends charging
// - Host selects safety duration by register write
// - Expiry: 256us status and alert pulse, fault
// - Double rate in precharge, derating, input limit
// - Timer holds in overvoltage, temp fault, shutdown, sleep
// - Fifty second watchdog restarts on every write
// - Enable bit six: zero stops, one restarts
// - Watchdog expiry loads defaults, charging continues
// - Later write restores host mode, even after timer expiry
// - Above regulation threshold, current steps down progressively
// - Die shutdown stops charge and converter, holds safety timer, sends pulse
// - Restart only after die cools by margin
// - Fault classes drop system rail or charge only
// - Lockout or timer fault resets timer, others hold
// - Charge state: ready, busy, done, fault
// - Four bit fault codes as listed
// - Queued faults read one per read, then the current code
// - Watchdog timeout flag set by enabled expiry
// - Regulator low with input in lockout: code ten
// - Watchdog enable reads zero after reset
// - Host mode uses registers, standalone uses resistors
`timescale 1ns/1ps
module charger_timer_fault_supervisor #(
    parameter int unsigned PULSE_LEN  = 32'(charger_pkg::PULSE_CYCLES),
    parameter int unsigned WD_LEN     = 32'(charger_pkg::WD_CYCLES),
    parameter int unsigned TICK_LEN   = 32'(charger_pkg::TICK_CYCLES),
    parameter int unsigned DERATE_LEN = 32'(charger_pkg::DERATE_CYCLES),
    parameter int          SAFETY_MIN_0 = 30,
    parameter int          SAFETY_MIN_1 = 60,
    parameter int          SAFETY_MIN_2 = 120,
    parameter int          SAFETY_MIN_3 = 240,
    parameter int          QUEUE_DEPTH  = 8,
    parameter logic [6:0]  DEV_ADDR     = 7'h35
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire charger_pkg::sense_type sense,
    output logic                        stat_out,
    output logic                        stat_oe,
    output logic                        alert_out,
    output logic                        alert_oe,
    output logic                        sys_enable,
    output logic                        charge_enable,
    output logic                        converter_enable,
    output logic                        host_mode,
    output logic                        load_defaults,
    output logic [2:0]                  derate_level
);
    import charger_pkg::*;

    localparam int PW = $clog2(PULSE_LEN + 1);
    localparam int WW = $clog2(WD_LEN + 1);
    localparam int TW = $clog2(TICK_LEN + 1);
    localparam int DW = $clog2(DERATE_LEN + 1);
    localparam int QA = $clog2(QUEUE_DEPTH);
    localparam int NF = NUM_FAULTS;
    localparam logic [2:0] DERATE_MAX = 3'h7;

    typedef struct packed {
        logic                        watchdog_enable_bit;
        logic                        wd_flag;
        logic [WW-1:0]               wd_cnt;
        logic                        host_mode;
        logic                        load_def;
        logic [TW-1:0]               tick_cnt;
        logic [DW-1:0]               der_cnt;
        logic [2:0]                  derate;
        logic [15:0]                 safe_cnt;
        logic                        safe_exp;
        logic                        tsd;
        logic [1:0]                  tsel;
        logic [NF-1:0]               prev;
        logic [NF-1:0]               pend;
        logic [3:0]                  cur_code;
        logic [1:0]                  chg_state;
        logic [QUEUE_DEPTH-1:0][3:0] q;
        logic [QA-1:0]               head;
        logic [QA-1:0]               tail;
        logic [QA:0]                 fill;
        logic [PW-1:0]               pulse_cnt;
        logic                        pin_oe;
        logic                        sys_en;
        logic                        chg_en;
        logic                        conv_en;
    } sup_state_type;

    sup_state_type r;
    sup_state_type n;
    regbus_type    bus;
    logic [7:0]    rd_data;

    serial_reg_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .clock   (clock),
        .rst_b   (rst_b),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .bus     (bus),
        .rd_data (rd_data)
    );

    // Read data comes from registered state only, so it is stable per bit
    always_comb begin
        rd_data = '0;
        if (bus.addr == REG_STATUS) begin
            rd_data[WD_FLAG_BIT] = r.wd_flag;
            rd_data[WATCHDOG_ENABLE_BIT_BIT] = r.watchdog_enable_bit;
            rd_data[STATE_LO +: 2] = r.chg_state;
            rd_data[FAULT_LO +: 4] = (r.fill != '0) ? r.q[r.head] : r.cur_code;
        end else if (bus.addr == REG_TIMER) begin
            rd_data[TSEL_LO +: 2] = r.tsel;
        end
    end

    always_comb begin
        logic [NF-1:0] cond;
        logic [NF-1:0] rise;
        logic [NF-1:0] pick;
        logic [3:0]    now_code;
        logic [3:0]    push_code;
        logic [15:0]   limit;
        logic          tick;
        logic          fast;
        logic          hold;
        logic          push;
        logic          pop;
        logic          any_fault;
        logic          status_read;
        cond = '0;
        pick = '0;
        now_code = FC_NORMAL;
        push_code = FC_NORMAL;
        n = r;
        n.load_def = 1'b0;

        cond[FC_IN_OVP - 1] = sense.in_ovp;
        cond[FC_IN_UVLO - 1] = sense.in_uvlo;
        cond[FC_SLEEP - 1] = sense.sleep;
        cond[FC_BAT_TEMP - 1] = sense.bat_temp_fault;
        cond[FC_BAT_OVP - 1] = sense.bat_ovp;
        cond[FC_TSD - 1] = r.tsd;
        cond[FC_TIMER - 1] = r.safe_exp;
        cond[FC_NO_BAT - 1] = sense.no_battery;
        cond[FC_SET_SHORT - 1] = sense.set_pin_short;
        cond[FC_LDO_LOW - 1] = sense.ldo_low & (sense.in_uvlo | r.prev[FC_IN_UVLO - 1]);
        rise = cond & ~r.prev;
        n.prev = cond;

        for (int i = NF - 1; i >= 0; i--) begin
            if (cond[i]) begin
                now_code = 4'(i + 1);
            end
            if (r.pend[i]) begin
                push_code = 4'(i + 1);
                pick = '0;
                pick[i] = 1'b1;
            end
        end
        n.cur_code = now_code;
        any_fault = (now_code != FC_NORMAL);

        if (any_fault) begin
            n.chg_state = CS_FAULT;
        end else if (sense.charge_done) begin
            n.chg_state = CS_DONE;
        end else if (sense.charge_active && r.chg_en) begin
            n.chg_state = CS_BUSY;
        end else begin
            n.chg_state = CS_READY;
        end

        status_read = bus.rd_done && (bus.addr == REG_STATUS);
        pop = status_read && (r.fill != '0);
        push = (r.pend != '0) && ((r.fill != (QA + 1)'(QUEUE_DEPTH)) || pop);
        // New events win over the bit being drained this cycle
        n.pend = (r.pend & ~(push ? pick : '0)) | rise;
        if (pop) begin
            n.head = QA'(r.head + 1'b1);
        end
        if (push) begin
            n.q[r.tail] = push_code;
            n.tail = QA'(r.tail + 1'b1);
        end
        if (push && !pop) begin
            n.fill = (QA + 1)'(r.fill + 1'b1);
        end else if (pop && !push) begin
            n.fill = (QA + 1)'(r.fill - 1'b1);
        end

        if (rise != '0) begin
            n.pulse_cnt = PW'(PULSE_LEN - 1);
            n.pin_oe = 1'b1;
        end else if (r.pulse_cnt != '0) begin
            n.pulse_cnt = r.pulse_cnt - 1'b1;
        end else begin
            n.pin_oe = 1'b0;
        end

        tick = (r.tick_cnt == TW'(TICK_LEN - 1));
        n.tick_cnt = tick ? '0 : TW'(r.tick_cnt + 1'b1);

        if (sense.die_over_shutdown) begin
            n.tsd = 1'b1;
        end else if (sense.die_below_restart) begin
            n.tsd = 1'b0;
        end

        unique case (r.tsel)
            2'h0: limit = 16'(SAFETY_MIN_0 * SEC_PER_MIN);
            2'h1: limit = 16'(SAFETY_MIN_1 * SEC_PER_MIN);
            2'h2: limit = 16'(SAFETY_MIN_2 * SEC_PER_MIN);
            2'h3: limit = 16'(SAFETY_MIN_3 * SEC_PER_MIN);
        endcase

        fast = sense.precharge_linear | sense.therm_reg | sense.bat_temp_reduced
             | sense.in_limit;
        hold = sense.in_ovp | sense.bat_temp_fault | r.tsd | sense.sleep
             | sense.no_battery | sense.set_pin_short | sense.in_good_fault
             | sense.bat_ovp;

        if (sense.in_uvlo) begin
            n.safe_cnt = '0;
            n.safe_exp = 1'b0;
        end else if (!sense.charge_active || r.safe_exp) begin
            n.safe_cnt = '0;
        end else if (tick && !hold && !sense.charge_done) begin
            n.safe_cnt = r.safe_cnt + (fast ? RATE_FAST : RATE_NORMAL);
            if (n.safe_cnt >= limit) begin
                n.safe_exp = 1'b1;
                n.safe_cnt = '0;
            end
        end

        if (status_read) begin
            n.wd_flag = 1'b0;
        end
        if (bus.wr) begin
            n.wd_cnt = '0;
            n.host_mode = 1'b1;
            if (bus.addr == REG_STATUS) begin
                n.watchdog_enable_bit = bus.wdata[WATCHDOG_ENABLE_BIT_BIT];
            end else if (bus.addr == REG_TIMER) begin
                n.tsel = bus.wdata[TSEL_LO +: 2];
            end
        end else if (r.watchdog_enable_bit && r.host_mode) begin
            if (r.wd_cnt == WW'(WD_LEN - 1)) begin
                n.wd_cnt = '0;
                n.host_mode = 1'b0;
                n.load_def = 1'b1;
                n.wd_flag = 1'b1;
            end else begin
                n.wd_cnt = WW'(r.wd_cnt + 1'b1);
            end
        end

        if (r.der_cnt == DW'(DERATE_LEN - 1)) begin
            n.der_cnt = '0;
            if (sense.therm_reg && r.derate != DERATE_MAX) begin
                n.derate = r.derate + 3'h1;
            end else if (!sense.therm_reg && r.derate != '0) begin
                n.derate = r.derate - 3'h1;
            end
        end else begin
            n.der_cnt = DW'(r.der_cnt + 1'b1);
        end

        n.sys_en = ~(sense.in_ovp | sense.in_uvlo | sense.sleep | r.tsd
                   | sense.in_good_fault);
        n.conv_en = ~(sense.in_ovp | sense.in_uvlo | sense.sleep | r.tsd);
        n.chg_en = n.sys_en & ~(sense.bat_temp_fault | r.safe_exp | sense.no_battery
                   | sense.set_pin_short | sense.bat_ovp | cond[FC_LDO_LOW - 1]);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign stat_out = 1'b0;
    assign alert_out = 1'b0;
    assign stat_oe = r.pin_oe;
    assign alert_oe = r.pin_oe;
    assign sys_enable = r.sys_en;
    assign charge_enable = r.chg_en;
    assign converter_enable = r.conv_en;
    assign host_mode = r.host_mode;
    assign load_defaults = r.load_def;
    assign derate_level = r.derate;

endmodule // charger_timer_fault_supervisor

/* test/host_master_model.sv */
/* Host model: two-wire master with register write and read tasks.
   Assumes a pull-up on the data line outside this module. */
`timescale 1ns/1ps
module host_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Half of the 320 ns link period
    localparam time H = 160ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bx(input logic b, output logic r);
        sda_low = !b;
        #H scl = 1'b1;
        #H r = sda;
        scl = 1'b0;
    endtask
    // Nine bits, the last one the acknowledge slot
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bx(d[i], q[i]);
    endtask
    // Start when a is 0, stop when a is 1
    task automatic sc(input logic a);
        // Data is set with the clock low, then moves while it is high for start and stop
        sda_low = a;
        #H scl = 1'b1;
        #H sda_low = !a;
        #H scl = a;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [8:0] q;
        sc(1'b0);
        xb(9'h0d5, q);
        xb({p, 1'b1}, q);
        xb({d, 1'b1}, q);
        sc(1'b1);
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [8:0] q;
        sc(1'b0);
        xb(9'h0d5, q);
        xb({p, 1'b1}, q);
        sc(1'b0);
        xb(9'h0d7, q);
        xb(9'h1ff, q);
        d = q[8:1];
        sc(1'b1);
    endtask
endmodule // host_master_model

/* test/charger_chk.sv */
/* Port checker for the supervisor, bound into the design.
   Assumes one core clock and the pulse length given by the bind. */
`timescale 1ns/1ps
module charger_chk #(
    parameter int unsigned PULSE_LEN = 8
) (
    input wire logic                   clock,
    input wire logic                   rst_b,
    input wire charger_pkg::sense_type sense,
    input wire logic                   stat_oe,
    input wire logic                   alert_oe,
    input wire logic                   sys_enable,
    input wire logic                   charge_enable,
    input wire logic                   converter_enable,
    input wire logic                   host_mode,
    input wire logic                   load_defaults,
    input wire logic [2:0]             derate_level
);
    import charger_pkg::*;
    int unsigned run_r;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clock) run_r <= (rst_b && stat_oe) ? run_r + 1 : 0;
    sequence s_hot; sense.die_over_shutdown ##1 !sense.die_below_restart [*3]; endsequence
    property p_pulse; $fell(stat_oe) |-> run_r == PULSE_LEN; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length");
    property p_pair; stat_oe == alert_oe; endproperty
    a_pair: assert property (p_pair) else $error("alert apart");
    property p_sys; sense.in_ovp || sense.in_uvlo || sense.sleep |-> ##[1:2] !sys_enable;
    endproperty
    a_sys: assert property (p_sys) else $error("rail on");
    property p_chg; sense.bat_temp_fault || sense.no_battery |-> ##[1:2] !charge_enable;
    endproperty
    a_chg: assert property (p_chg) else $error("charge on");
    property p_keep; $rose(sense.no_battery) && sys_enable |=> sys_enable; endproperty
    a_keep: assert property (p_keep) else $error("rail dropped");
    property p_hot; s_hot |-> !converter_enable && !sys_enable; endproperty
    a_hot: assert property (p_hot) else $error("hot running");
    property p_dflt; load_defaults |=> !load_defaults && !host_mode; endproperty
    a_dflt: assert property (p_dflt) else $error("defaults");
    property p_step; $changed(derate_level) |-> derate_level - $past(derate_level) inside
        {3'h1, 3'h7}; endproperty
    a_step: assert property (p_step) else $error("derate jump");
endmodule // charger_chk
bind charger_timer_fault_supervisor charger_chk #(.PULSE_LEN(PULSE_LEN)) i_charger_chk (
    .clock, .rst_b, .sense, .stat_oe, .alert_oe, .sys_enable, .charge_enable,
    .converter_enable, .host_mode, .load_defaults, .derate_level);

/* test/charger_timer_fault_supervisor_tb.sv */
/* Bench for the supervisor driven through the host model.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
module charger_timer_fault_supervisor_tb;
    import charger_pkg::*;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    sense_type  sense = '0;
    logic       scl, host_low, sda_oe, ld, hm, ce;
    logic [7:0] q;
    wire        sda = !(host_low || sda_oe);
    int         n_fail = 0;
    int         n_compared = 0;
    int         cyc = 0;
    int         n;
    int         pos[8] = '{10, 9, 8, 7, 6, 5, 3, 2};
    always #20 clock = !clock;
    host_master_model i_host_master_model (.scl, .sda_low(host_low), .sda);
    charger_timer_fault_supervisor #(.PULSE_LEN(8), .WD_LEN(200), .TICK_LEN(4),
        .DERATE_LEN(4), .SAFETY_MIN_1(2)) i_charger_timer_fault_supervisor (
        .clock, .rst_b, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .sense,
        .stat_out(), .stat_oe(), .alert_out(), .alert_oe(), .sys_enable(),
        .charge_enable(ce), .converter_enable(), .host_mode(hm), .load_defaults(ld),
        .derate_level());
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (n = 0; n < 1000 && s !== v; n++) @(negedge clock);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        i_host_master_model.rd(REG_STATUS, q);
        chk("wd_bits", 8'h00, q & 8'hc0);
        i_host_master_model.wr(REG_STATUS, 8'h40);
        chk("host_mode", 8'h01, 8'(hm));
        wait_for(ld, 1'b1);
        @(negedge clock);
        chk("wd_time", 8'h01, 8'(n >= 175 && n <= 190));
        chk("host_mode", 8'h00, 8'(hm));
        i_host_master_model.rd(REG_STATUS, q);
        chk("wd_flag", 8'h80, q & 8'h80);
        i_host_master_model.wr(REG_STATUS, 8'h00);
        i_host_master_model.rd(REG_STATUS, q);
        chk("wd_flag", 8'h00, q & 8'hc0);
        i_host_master_model.wr(REG_STATUS, 8'h40);
        chk("host_mode", 8'h01, 8'(hm));
        $display("test watchdog done");
        for (int i = 0; i < 8; i++) begin
            sense[pos[i]] = 1'b1;
            repeat (12) @(negedge clock);
            sense = '0;
            sense.die_below_restart = 1'b1;
            repeat (12) @(negedge clock);
            sense.die_below_restart = 1'b0;
        end
        for (int i = 0; i <= 8; i++) begin
            i_host_master_model.rd(REG_STATUS, q);
            chk("code", i == 8 ? 8'h00 : 8'(i < 6 ? i + 1 : i + 2), q & 8'h0f);
        end
        $display("test fault queue done");
        i_host_master_model.wr(REG_STATUS, 8'h00);
        i_host_master_model.wr(REG_TIMER, 8'h01);
        sense.charge_active = 1'b1;
        sense.precharge_linear = 1'b1;
        sense.therm_reg = 1'b1;
        wait_for(ce, 1'b0);
        chk("safety_time", 8'h01, 8'(n >= 232 && n <= 250));
        chk("host_mode", 8'h01, 8'(hm));
        i_host_master_model.rd(REG_STATUS, q);
        chk("timer_fault", 8'h37, q & 8'h3f);
        $display("test safety timer done");
        tally_and_finish;
    end
endmodule // charger_timer_fault_supervisor_tb
